// ---- logic/flash_result_pkg.sv ----
// package with register map, result-field layout and reset values of the routine result block
package flash_result_pkg;
  localparam logic [7:0] RESULT_OFFSET = 8'h00;
  localparam logic [7:0] CTRL_OFFSET = 8'h04;
  localparam logic [7:0] SRC_ADDR_OFFSET = 8'h08;
  localparam logic [7:0] DST_ADDR_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h14;
  localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h18;

  localparam int OUTCOME_BIT = 0;
  localparam int DEST_ERR_BIT = 1;
  localparam int SRC_ERR_BIT = 2;
  localparam int MODE_ERR_BIT = 6;
  localparam int START_PROG_BIT = 0;
  localparam int START_ERASE_BIT = 1;
  localparam int PROTECT_BIT = 0;
  localparam int IRQ_PROG_BIT = 0;
  localparam int IRQ_ERASE_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int ALIGN_BITS = 7;

  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {SEQ_IDLE, SEQ_EVAL} seq_t;
endpackage

// ---- logic/flash_addr_checker.sv ----
// address checker for the programming source buffer and destination
`timescale 1ns/1ns
module flash_addr_checker
  import flash_result_pkg::*;
#(
  parameter logic [31:0] FLASH_BASE = 32'h0000_0000,
  parameter logic [31:0] FLASH_SIZE = 32'h0004_0000
) (
  input wire logic [31:0] src_addr_in,
  input wire logic [31:0] dst_addr_in,
  output logic src_err_out,
  output logic dst_region_err_out,
  output logic dst_align_err_out
);
  generate
    if (FLASH_SIZE == 32'h0000_0000) begin : g_bad_size
      $error("flash region size must be nonzero");
    end
  endgenerate

  // offsets relative to base avoid overflow of base plus size at the top of memory
  logic [31:0] src_rel;
  logic [31:0] dst_rel;
  assign src_rel = src_addr_in - FLASH_BASE;
  assign dst_rel = dst_addr_in - FLASH_BASE;
  assign src_err_out = src_rel >= FLASH_SIZE;
  assign dst_region_err_out = dst_rel >= FLASH_SIZE;
  // low eight bits 00 or 80 means the low seven are clear
  assign dst_align_err_out = dst_addr_in[ALIGN_BITS-1:0] != '0;
endmodule // flash_addr_checker

// ---- logic/flash_op_result_flags.sv ----
// routine result flags with axi4-lite register slave and interrupt
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
// Contract
// - source flag bit 2 set when program data buffer start lies outside flash.
// - source flag reads 0 for a valid buffer start, 1 for an invalid one.
// - destination flag bit 1 set when destination start lies outside flash.
// - destination flag also set when destination low byte is neither 00 nor 80.
// - after programming bit 0 shows 0 on success, 1 on any error.
// - erasure results use the same 8-bit result value as programming.
// - after erasure bit 6 is 1 in error-protection state, else 0.
// - bit 6 always equals the protection bit of the control/status register.
module flash_op_result_flags
  import flash_result_pkg::*;
#(
  parameter int AXI_ADDR_W = 8,
  parameter logic [31:0] FLASH_BASE = 32'h0000_0000,
  parameter logic [31:0] FLASH_SIZE = 32'h0004_0000
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic protect_state_in,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic irq_out
);
  generate
    if (AXI_ADDR_W < 5 || AXI_ADDR_W > 32) begin : g_bad_addr_w
      $error("axi address width must be 5 to 32");
    end
  endgenerate

  typedef struct packed {
    logic aw_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [7:0] result;
    logic last_erase;
    seq_t seq;
    logic op_erase;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
  } state_t;

  state_t st;
  state_t next_st;
  logic src_err;
  logic dst_region_err;
  logic dst_align_err;
  logic dst_err;
  logic [7:0] result_view;

  flash_addr_checker #(
    .FLASH_BASE(FLASH_BASE),
    .FLASH_SIZE(FLASH_SIZE)
  ) i_flash_addr_checker (
    .src_addr_in(st.src_addr),
    .dst_addr_in(st.dst_addr),
    .src_err_out(src_err),
    .dst_region_err_out(dst_region_err),
    .dst_align_err_out(dst_align_err)
  );

  assign dst_err = dst_region_err | dst_align_err;

  // mode bit is live so it can never disagree with the protection bit
  always_comb begin
    result_view = '0;
    result_view[MODE_ERR_BIT] = protect_state_in;
    if (st.last_erase) begin
      result_view[OUTCOME_BIT] = st.result[OUTCOME_BIT];
    end else begin
      result_view[SRC_ERR_BIT:OUTCOME_BIT] = st.result[SRC_ERR_BIT:OUTCOME_BIT];
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [AXI_ADDR_W-1:0] reg_addr(input logic [7:0] off);
    return AXI_ADDR_W'(off);
  endfunction

  assign s_axi_awready_out = !st.aw_held && !st.bvalid;
  assign s_axi_wready_out = !st.w_held && !st.bvalid;
  assign s_axi_arready_out = !st.rvalid;
  assign s_axi_bvalid_out = st.bvalid;
  assign s_axi_bresp_out = st.bresp;
  assign s_axi_rvalid_out = st.rvalid;
  assign s_axi_rdata_out = st.rdata;
  assign s_axi_rresp_out = st.rresp;
  assign irq_out = |(st.irq_status & st.irq_mask);

  always_comb begin
    next_st = st;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata_in;
      next_st.w_strb = s_axi_wstrb_in;
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
    // address and data both held: perform the write, answer next cycle
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (st.aw_addr == reg_addr(RESULT_OFFSET)) begin
        // result is produced by the routine; software writes are dropped
        next_st.bresp = RESP_OKAY;
      end else if (st.aw_addr == reg_addr(CTRL_OFFSET)) begin
        // a start while a routine is evaluating is ignored
        if (st.seq == SEQ_IDLE && st.w_strb[0]) begin
          if (st.w_data[START_PROG_BIT]) begin
            next_st.seq = SEQ_EVAL;
            next_st.op_erase = 1'b0;
          end else if (st.w_data[START_ERASE_BIT]) begin
            next_st.seq = SEQ_EVAL;
            next_st.op_erase = 1'b1;
          end
        end
      end else if (st.aw_addr == reg_addr(SRC_ADDR_OFFSET)) begin
        next_st.src_addr = merge(st.src_addr, st.w_data, st.w_strb);
      end else if (st.aw_addr == reg_addr(DST_ADDR_OFFSET)) begin
        next_st.dst_addr = merge(st.dst_addr, st.w_data, st.w_strb);
      end else if (st.aw_addr == reg_addr(IRQ_STATUS_OFFSET)) begin
        next_st.bresp = RESP_OKAY;
      end else if (st.aw_addr == reg_addr(IRQ_MASK_OFFSET)) begin
        if (st.w_strb[0]) begin
          next_st.irq_mask = st.w_data[IRQ_W-1:0];
        end
      end else if (st.aw_addr == reg_addr(CTRL_STATUS_OFFSET)) begin
        next_st.bresp = RESP_OKAY;
      end else begin
        next_st.bresp = RESP_SLVERR;
      end
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = '0;
      if (s_axi_araddr_in == reg_addr(RESULT_OFFSET)) begin
        next_st.rdata[7:0] = result_view;
      end else if (s_axi_araddr_in == reg_addr(CTRL_OFFSET)) begin
        next_st.rdata[0] = st.seq == SEQ_EVAL;
      end else if (s_axi_araddr_in == reg_addr(SRC_ADDR_OFFSET)) begin
        next_st.rdata = st.src_addr;
      end else if (s_axi_araddr_in == reg_addr(DST_ADDR_OFFSET)) begin
        next_st.rdata = st.dst_addr;
      end else if (s_axi_araddr_in == reg_addr(IRQ_STATUS_OFFSET)) begin
        next_st.rdata[IRQ_W-1:0] = st.irq_status;
        next_st.irq_status = '0;
      end else if (s_axi_araddr_in == reg_addr(IRQ_MASK_OFFSET)) begin
        next_st.rdata[IRQ_W-1:0] = st.irq_mask;
      end else if (s_axi_araddr_in == reg_addr(CTRL_STATUS_OFFSET)) begin
        next_st.rdata[PROTECT_BIT] = protect_state_in;
      end else begin
        next_st.rresp = RESP_SLVERR;
      end
    end
    // routine completion comes after the read clear so a new event is kept
    if (st.seq == SEQ_EVAL) begin
      next_st.seq = SEQ_IDLE;
      next_st.last_erase = st.op_erase;
      next_st.result = RESULT_RESET;
      if (st.op_erase) begin
        next_st.result[OUTCOME_BIT] = protect_state_in;
        next_st.result[MODE_ERR_BIT] = protect_state_in;
        next_st.irq_status[IRQ_ERASE_BIT] = 1'b1;
      end else begin
        next_st.result[SRC_ERR_BIT] = src_err;
        next_st.result[DEST_ERR_BIT] = dst_err;
        next_st.result[OUTCOME_BIT] = src_err | dst_err | protect_state_in;
        next_st.irq_status[IRQ_PROG_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.src_addr <= ADDR_RESET;
      st.dst_addr <= ADDR_RESET;
      st.result <= RESULT_RESET;
      st.irq_mask <= IRQ_MASK_RESET;
      st.seq <= SEQ_IDLE;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic prog_eval;
  logic erase_eval;
  assign prog_eval = st.seq == SEQ_EVAL && !st.op_erase;
  assign erase_eval = st.seq == SEQ_EVAL && st.op_erase;

  a_src_flag_set: assert property (prog_eval |=> result_view[SRC_ERR_BIT] == $past(src_err))
    else $error("source flag does not match buffer address check");
  a_src_flag_ok: assert property (prog_eval && !src_err |=> !result_view[SRC_ERR_BIT])
    else $error("source flag set for a valid buffer address");
  a_dst_region: assert property (prog_eval && dst_region_err |=> result_view[DEST_ERR_BIT])
    else $error("destination outside flash not flagged");
  a_dst_align: assert property (prog_eval && st.dst_addr[6:0] != 7'h00
                                |=> result_view[DEST_ERR_BIT])
    else $error("misaligned destination not flagged");
  a_dst_ok: assert property (prog_eval && !dst_err |=> !result_view[DEST_ERR_BIT])
    else $error("destination flag set for a valid destination");
  a_prog_outcome: assert property (prog_eval |=> result_view[OUTCOME_BIT] ==
                                   $past(src_err || dst_err || protect_state_in))
    else $error("programming outcome bit wrong");
  a_prog_format: assert property (prog_eval |=>
                                  result_view[5:3] == 3'h0 && !result_view[7])
    else $error("unused bit set in programming result");
  a_erase_format: assert property (erase_eval |=> st.last_erase &&
                                   st.seq == SEQ_IDLE &&
                                   result_view[OUTCOME_BIT] == $past(protect_state_in))
    else $error("erase result not in result value");
  a_mode_flag: assert property (st.last_erase |->
                                result_view[MODE_ERR_BIT] == protect_state_in)
    else $error("mode flag does not track protection state");
  a_mode_mirror: assert property (result_view[MODE_ERR_BIT] == protect_state_in)
    else $error("mode flag disagrees with protection state");
  a_unused_zero: assert property (result_view[7] == 1'b0 && result_view[5:3] == 3'h0 &&
                                  (!st.last_erase || result_view[2:1] == 2'h0))
    else $error("unused result bit reads nonzero");
  a_irq_level: assert property (erase_eval |=> st.irq_status[IRQ_ERASE_BIT]
                                ##0 (irq_out == |(st.irq_status & st.irq_mask)))
    else $error("erase completion did not raise status");

  c_prog_fail: cover property (prog_eval ##1 result_view[OUTCOME_BIT]);
  c_prog_ok: cover property (prog_eval ##1 !result_view[OUTCOME_BIT]);
  c_erase_protect: cover property (erase_eval && protect_state_in ##1 result_view[MODE_ERR_BIT]);
  c_irq: cover property (irq_out ##[1:20] !irq_out);
  c_prog_protect: cover property (prog_eval && protect_state_in ##1 result_view[MODE_ERR_BIT]);

  // completion and read-clear of the event status
  a_irq_prog: assert property (prog_eval |=> st.irq_status[IRQ_PROG_BIT])
    else $error("program completion did not raise status");
  a_irq_clear: assert property (s_axi_arvalid_in && s_axi_arready_out &&
                                s_axi_araddr_in == reg_addr(IRQ_STATUS_OFFSET) &&
                                st.seq == SEQ_IDLE |=> st.irq_status == '0)
    else $error("status read did not clear the events");
  // a routine evaluates for one cycle only, so a start written meanwhile is dropped
  a_eval_once: assert property (st.seq == SEQ_EVAL |=> st.seq == SEQ_IDLE)
    else $error("routine evaluation lasted more than one cycle");
  // the result moves only at completion, so software never reads a half update
  a_result_hold: assert property (st.seq == SEQ_IDLE |=>
                                  $stable(st.result) && $stable(st.last_erase))
    else $error("result changed with no routine running");

  // answers stand until taken; no new request is accepted while an answer of the same kind is pending
  a_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
                                  s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped before it was taken");
  a_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
                                  s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped before it was taken");
  a_write_refused: assert property (s_axi_bvalid_out |->
                                    !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while a response is pending");
  a_read_refused: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted while data is pending");
endmodule // flash_op_result_flags

// ---- testbench/flash_op_result_flags_tb.sv ----
// self-checking bench for the routine result flags block, driven over axi4-lite
`timescale 1ns/1ns
module flash_op_result_flags_tb;
  import flash_result_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic protect = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  int n_fail = 0;
  int checks = 0;

  flash_op_result_flags i_flash_op_result_flags (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .protect_state_in(protect),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .irq_out(irq)
  );

  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic close_out;
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // handshakes are judged at the falling edge, where the coming rising edge will see them
  // no cycle count is assumed: only the watchdog ends a wait for an answer
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_go, w_go, b_go;
    @(posedge core_clk_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_go = 1'b0;
    while (!b_go) begin
      @(negedge core_clk_in);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid;
      resp = bresp;
      @(posedge core_clk_in);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    logic ar_go, r_go;
    @(posedge core_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_go = 1'b0;
    while (!r_go) begin
      @(negedge core_clk_in);
      ar_go = arvalid && arready;
      r_go = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge core_clk_in);
      if (ar_go) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // start a routine; the result lands one edge after the start write
  task automatic run(input logic [31:0] start);
    axi_write(CTRL_OFFSET, start);
    repeat (2) @(posedge core_clk_in);
  endtask

  task automatic prog(input logic [31:0] src, input logic [31:0] dst, input logic [7:0] exp);
    axi_write(SRC_ADDR_OFFSET, src);
    axi_write(DST_ADDR_OFFSET, dst);
    run(32'h0000_0001);
    axi_read(RESULT_OFFSET);
    check(rd, {24'h00_0000, exp});
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    axi_read(RESULT_OFFSET);
    check(rd, 32'h0000_0000);
    axi_read(8'h1C);
    check({rd[29:0], resp}, {30'h0, RESP_SLVERR});
    axi_write(8'h1C, 32'h0000_0000);
    check(resp, RESP_SLVERR);
    axi_write(IRQ_MASK_OFFSET, 32'h0000_0003);
    // boundary addresses on both sides of the flash limit and the 128-byte grid
    prog(32'h0003_FFFF, 32'h0000_1000, 8'h00);
    check(irq, 1'b1);
    axi_read(IRQ_STATUS_OFFSET);
    check(rd, 32'h0000_0001);
    check(irq, 1'b0);
    prog(32'h0004_0000, 32'h0000_1080, 8'h05);
    prog(32'h0000_0100, 32'h0004_0000, 8'h03);
    prog(32'h0000_0100, 32'h0000_1040, 8'h03);
    prog(32'h0000_0100, 32'h0000_1001, 8'h03);
    axi_write(RESULT_OFFSET, 32'h0000_00FF);
    axi_read(RESULT_OFFSET);
    check(rd, 32'h0000_0003);
    // erase while protected: flag mirrors the protection bit
    protect <= 1'b1;
    run(32'h0000_0002);
    axi_read(RESULT_OFFSET);
    check(rd, 32'h0000_0041);
    axi_read(CTRL_STATUS_OFFSET);
    check(rd, 32'h0000_0001);
    protect <= 1'b0;
    axi_read(RESULT_OFFSET);
    check(rd, 32'h0000_0001);
    axi_read(IRQ_STATUS_OFFSET);
    check(rd, 32'h0000_0003);
    run(32'h0000_0002);
    axi_read(RESULT_OFFSET);
    check(rd, 32'h0000_0000);
    // protected program: outcome fails and the mode bit follows the protection state
    protect <= 1'b1;
    prog(32'h0000_0100, 32'h0000_1080, 8'h41);
    protect <= 1'b0;
    // masked event stays pending without raising the line
    axi_write(IRQ_MASK_OFFSET, 32'h0000_0000);
    axi_read(IRQ_STATUS_OFFSET);
    check(rd, 32'h0000_0003);
    prog(32'h0000_0100, 32'h0000_1080, 8'h00);
    check(irq, 1'b0);
    axi_read(IRQ_STATUS_OFFSET);
    check(rd, 32'h0000_0001);
    close_out();
  end
endmodule // flash_op_result_flags_tb
